// ---- iop_pkg.sv ----
// package for the four-port i/o block
package iop_pkg;
  localparam logic [31:0] ADR_PORT0 = 32'h0000_0000;
  localparam logic [31:0] ADR_PORT1 = 32'h0000_0004;
  localparam logic [31:0] ADR_PORT2 = 32'h0000_0008;
  localparam logic [31:0] ADR_PORT3 = 32'h0000_000c;
  localparam logic [31:0] ADR_P0_MODE = 32'h0000_0010;
  localparam logic [31:0] ADR_P2_MODE = 32'h0000_0014;
  localparam logic [31:0] ADR_P3_MODE = 32'h0000_0018;
  localparam logic [31:0] ADR_PCFG = 32'h0000_001c;
  localparam logic [31:0] ADR_IRQ_EDGE = 32'h0000_0020;
  localparam logic [31:0] ADR_TMR8 = 32'h0000_0024;
  localparam logic [31:0] ADR_TMRC = 32'h0000_0028;
  localparam logic [31:0] ADR_TMR16 = 32'h0000_002c;
  localparam logic [31:0] ADR_RMW = 32'h0000_0030;
  localparam logic [31:0] ADR_STATUS = 32'h0000_0034;
  localparam logic [31:0] ADR_RST_CTRL = 32'h0000_0038;
  localparam logic [1:0] OP_OR = 2'h1;
  localparam logic [1:0] OP_AND = 2'h2;
  localparam logic [1:0] OP_XOR = 2'h3;
  localparam int RMW_PORT_LSB = 8;
  localparam int RMW_OP_LSB = 10;
  localparam int PCFG_CMP1_BIT = 0;
  localparam int PCFG_P1_OD_BIT = 1;
  localparam int PCFG_P0_OD_BIT = 2;
  localparam int PCFG_P2_OD_BIT = 3;
  localparam int PCFG_CMP2_BIT = 4;
  localparam int P3M_ANALOG_BIT = 1;
  localparam int P3M_P2IN_BIT = 2;
  localparam int IRQ_SEL_LSB = 6;
  localparam int TMR_PIN_BIT = 0;
  localparam int TMRC_SEL_LSB = 4;
  localparam logic [7:0] PCFG_RST = 8'h00;
  localparam logic [7:0] ALL_IN = 8'h00;
  localparam logic [7:0] RSVD_READ = 8'hff;
  localparam int CLK_HZ = 20_000_000;
  localparam int POR_TIME_US = 1000;
  localparam int POR_CYCLES = POR_TIME_US * (CLK_HZ / 1_000_000);
  typedef struct packed {
    logic [7:0] in;
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu_en;
  } iop_pin_s;
  typedef enum logic [1:0] {
    EDGE_NONE_E, EDGE_RISE_E, EDGE_FALL_E, EDGE_BOTH_E
  } iop_edge_e;
endpackage

// ---- iop_ports.sv ----
// four 8-bit i/o ports with reset pin and wishbone register slave
// Operation
// - reads return synchronised pin level
// - or/and/xor read pins, write latch
// - pull-up off when pin is output
// - port 0 direction set per nibble
// - port config d2: port 0 open-drain
// - port 0 input after reset, recovery
// - port config d1: port 1 open-drain
// - port 1 input after reset, recovery
// - small package: port 1 reads ff
// - port 2 per-bit direction, global drive
// - port 2 all inputs after reset
// - port 2 or/and gates for wake-up
// - edge input from port3 bit1 or port2 bit0
// - port 3 low in, high out fixed
// - port 3 mode bit 1 selects analog
// - port 3 bit1/2 edge irq select
// - analog: bit3 goes to recovery sources
// - digital: bit3 is d3, raises irq
// - stop powers down comparators
// - timer control routes port 3 outputs
// - port config routes comparators to 4,7
// - device drives reset low on por/watchdog
// - port data at register locations 0-3
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module iop_ports
  import iop_pkg::*;
#(
  parameter int unsigned POR_LEN = POR_CYCLES,
  parameter bit SMALL_PKG = 1'b0
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // wishbone slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [31:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // port pins
  input wire logic [7:0] P0_IN,
  output logic [7:0] P0_OUT,
  output logic [7:0] P0_OE,
  output logic [7:0] P0_PU_EN,
  input wire logic [7:0] P1_IN,
  output logic [7:0] P1_OUT,
  output logic [7:0] P1_OE,
  output logic [7:0] P1_PU_EN,
  input wire logic [7:0] P2_IN,
  output logic [7:0] P2_OUT,
  output logic [7:0] P2_OE,
  output logic [7:0] P2_PU_EN,
  input wire logic [3:0] P3_IN,
  output logic [7:4] P3_OUT,
  // analog and timer side
  input wire logic CMP1_OUT,
  input wire logic CMP2_OUT,
  output logic CMP_PWR_EN,
  input wire logic T8_OUT,
  input wire logic T16_OUT,
  input wire logic ANDOR_OUT,
  output logic EDGE_IN,
  output logic [2:0] PORT3_IRQ,
  // power state
  input wire logic STOP_MODE,
  input wire logic STOP_RECOVERY,
  input wire logic BROWN_OUT_CONDITION,
  input wire logic POR_EVENT,
  input wire logic WDT_EVENT,
  output logic [7:0] WAKE_SOURCES,
  // reset pin
  input wire logic RESET_PIN_IN_N,
  output logic RESET_PIN_OUT_N,
  output logic RESET_PIN_OE,
  output logic RESET_PIN_PU_EN,
  output logic INT_RESET_N
);
  logic [7:0] s0_ff, s1_ff, s2_ff, p0_ff, p1_ff, p2_ff;
  logic [3:0] s3_ff, p3_ff, p3_prev_ff;
  logic s_rst_ff, p_rst_ff;
  logic [7:0] lat0_ff, lat1_ff, lat2_ff;
  logic [7:4] lat3_ff;
  logic [1:0] p0_dir_ff;
  logic [7:0] p1_dir_ff, p2_dir_ff, pcfg_ff, irq_ff, p3m_ff;
  logic [7:0] tmr8_ff, tmrc_ff, tmr16_ff;
  logic [31:0] cnt_ff;
  logic drv_ff, ack_ff;
  logic [31:0] dat_ff;
  logic [2:0] irq_ev;
  logic [2:1] cmp_prev_ff;
  logic [2:1] src_now, src_was;
  logic [7:0] rd_pin, rd_p1, wdat, mod_val, nxt_latch;
  logic [1:0] rmw_port, rmw_op;
  logic wr, rd, analog, req;
  iop_pin_s pin0, pin1, pin2;

  // pin synchronisers
  always_ff @(posedge SYS_CLK) begin
    s0_ff <= P0_IN;
    s1_ff <= P1_IN;
    s2_ff <= P2_IN;
    s3_ff <= P3_IN;
    p0_ff <= s0_ff;
    p1_ff <= s1_ff;
    p2_ff <= s2_ff;
    p3_ff <= s3_ff;
    p3_prev_ff <= p3_ff;
  end

  // reset pin synchroniser
  always_ff @(posedge SYS_CLK) begin
    s_rst_ff <= RESET_PIN_IN_N;
    p_rst_ff <= s_rst_ff;
  end

  assign req = WB_CYC && WB_STB && !ack_ff;
  assign wr = req && WB_WE && WB_SEL[0];
  assign rd = req && !WB_WE;
  assign wdat = WB_DAT_I[7:0];
  assign analog = p3m_ff[P3M_ANALOG_BIT];
  assign rmw_port = WB_DAT_I[RMW_PORT_LSB +: 2];
  assign rmw_op = WB_DAT_I[RMW_OP_LSB +: 2];
  assign rd_p1 = SMALL_PKG ? RSVD_READ : p1_ff;

  // read-modify-write on pin levels
  // port 3 outputs have no input buffer, so the latch stands in
  always_comb begin
    unique case (rmw_port)
      2'h0: rd_pin = p0_ff;
      2'h1: rd_pin = rd_p1;
      2'h2: rd_pin = p2_ff;
      default: rd_pin = {lat3_ff, p3_ff};
    endcase
    unique case (rmw_op)
      OP_OR: mod_val = rd_pin | wdat;
      OP_AND: mod_val = rd_pin & wdat;
      OP_XOR: mod_val = rd_pin ^ wdat;
      default: mod_val = rd_pin;
    endcase
    nxt_latch = mod_val;
  end

  // output latches
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      lat0_ff <= 8'h00;
      lat1_ff <= 8'h00;
      lat2_ff <= 8'h00;
      lat3_ff <= 4'h0;
    end else if (wr && WB_ADR == ADR_RMW && rmw_op != 2'h0) begin
      unique case (rmw_port)
        2'h0: lat0_ff <= nxt_latch;
        2'h1: lat1_ff <= SMALL_PKG ? lat1_ff : nxt_latch;
        2'h2: lat2_ff <= nxt_latch;
        default: lat3_ff <= nxt_latch[7:4];
      endcase
    end else if (wr) begin
      if (WB_ADR == ADR_PORT0) lat0_ff <= wdat;
      if (WB_ADR == ADR_PORT1 && !SMALL_PKG) lat1_ff <= wdat;
      if (WB_ADR == ADR_PORT2) lat2_ff <= wdat;
      if (WB_ADR == ADR_PORT3) lat3_ff <= wdat[7:4];
    end
  end

  // port 0 direction, cleared by reset and stop-mode recovery
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || STOP_RECOVERY) begin
      p0_dir_ff <= 2'h0;
    end else if (wr && WB_ADR == ADR_P0_MODE) begin
      p0_dir_ff <= wdat[1:0];
    end
  end

  // port 1 has no direction register: held as input
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || STOP_RECOVERY) begin
      p1_dir_ff <= ALL_IN;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      p2_dir_ff <= ALL_IN;
    end else if (wr && WB_ADR == ADR_P2_MODE) begin
      p2_dir_ff <= wdat;
    end
  end

  // configuration registers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pcfg_ff <= PCFG_RST;
      irq_ff <= 8'h00;
      p3m_ff <= 8'h00;
      tmr8_ff <= 8'h00;
      tmrc_ff <= 8'h00;
      tmr16_ff <= 8'h00;
    end else if (wr) begin
      if (WB_ADR == ADR_PCFG) pcfg_ff <= wdat;
      if (WB_ADR == ADR_IRQ_EDGE) irq_ff <= wdat;
      if (WB_ADR == ADR_P3_MODE) p3m_ff <= wdat;
      if (WB_ADR == ADR_TMR8) tmr8_ff <= wdat;
      if (WB_ADR == ADR_TMRC) tmrc_ff <= wdat;
      if (WB_ADR == ADR_TMR16) tmr16_ff <= wdat;
    end
  end

  // pin drive: output enable, open-drain, pull-up
  always_comb begin
    pin0.in = p0_ff;
    pin0.oe = {{4{p0_dir_ff[1]}}, {4{p0_dir_ff[0]}}};
    pin0.out = lat0_ff;
    if (pcfg_ff[PCFG_P0_OD_BIT]) pin0.oe = pin0.oe & ~lat0_ff;
    pin0.pu_en = ~{{4{p0_dir_ff[1]}}, {4{p0_dir_ff[0]}}};
    pin1.in = rd_p1;
    pin1.oe = SMALL_PKG ? 8'h00 : p1_dir_ff;
    pin1.out = lat1_ff;
    if (pcfg_ff[PCFG_P1_OD_BIT]) pin1.oe = pin1.oe & ~lat1_ff;
    pin1.pu_en = ~p1_dir_ff;
    pin2.in = p2_ff;
    pin2.oe = p2_dir_ff;
    pin2.out = lat2_ff;
    if (pcfg_ff[PCFG_P2_OD_BIT]) pin2.oe = pin2.oe & ~lat2_ff;
    pin2.pu_en = ~p2_dir_ff;
  end

  assign P0_OUT = pin0.out;
  assign P0_OE = pin0.oe;
  assign P0_PU_EN = pin0.pu_en;
  assign P1_OUT = pin1.out;
  assign P1_OE = pin1.oe;
  assign P1_PU_EN = pin1.pu_en;
  assign P2_OUT = pin2.out;
  assign P2_OE = pin2.oe;
  assign P2_PU_EN = pin2.pu_en;

  // port 3 output routing, fixed push-pull outputs
  always_comb begin
    P3_OUT = lat3_ff;
    if (tmr8_ff[TMR_PIN_BIT]) P3_OUT[4] = T8_OUT;
    if (pcfg_ff[PCFG_CMP1_BIT]) P3_OUT[4] = CMP1_OUT;
    if (tmr16_ff[TMR_PIN_BIT]) P3_OUT[5] = T16_OUT;
    unique case (tmrc_ff[TMRC_SEL_LSB +: 2])
      2'h1: P3_OUT[6] = T8_OUT;
      2'h2: P3_OUT[6] = T16_OUT;
      2'h3: P3_OUT[6] = ANDOR_OUT;
      default: P3_OUT[6] = lat3_ff[6];
    endcase
    if (pcfg_ff[PCFG_CMP2_BIT]) P3_OUT[7] = CMP2_OUT;
  end

  // edge detect input and port 3 interrupts
  assign EDGE_IN = p3m_ff[P3M_P2IN_BIT] ? p2_ff[0] : p3_ff[1];
  assign CMP_PWR_EN = analog && !STOP_MODE;

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic now, input logic was);
    logic r;
    r = 1'b0;
    unique case (iop_edge_e'(sel))
      EDGE_RISE_E: r = now && !was;
      EDGE_FALL_E: r = !now && was;
      EDGE_BOTH_E: r = now ^ was;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // comparator outputs replace pins 1 and 2 as edge sources in analog mode
  always_ff @(posedge SYS_CLK) begin
    cmp_prev_ff <= {CMP2_OUT, CMP1_OUT};
  end
  assign src_now = analog ? {CMP2_OUT, CMP1_OUT} : p3_ff[2:1];
  assign src_was = analog ? cmp_prev_ff : p3_prev_ff[2:1];

  // bit 2 edge -> irq 0, bit 3 fall -> irq 1, bit 1 edge -> irq 2
  always_comb begin
    irq_ev[0] = edge_hit(irq_ff[IRQ_SEL_LSB +: 2], src_now[2],
                         src_was[2]);
    irq_ev[2] = edge_hit(irq_ff[IRQ_SEL_LSB +: 2], src_now[1],
                         src_was[1]);
    irq_ev[1] = !analog && !p3_ff[3] && p3_prev_ff[3];
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) PORT3_IRQ <= 3'h0;
    else PORT3_IRQ <= irq_ev;
  end

  // wake-up sources: port 2 gates, digital port 3 and port 3 bit 3 in analog mode
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      WAKE_SOURCES <= 8'h00;
    end else begin
      WAKE_SOURCES[0] <= |p2_ff;
      WAKE_SOURCES[1] <= &p2_ff;
      WAKE_SOURCES[2] <= !analog && p3_ff[1];
      WAKE_SOURCES[3] <= !analog && p3_ff[2];
      WAKE_SOURCES[4] <= !analog && p3_ff[3];
      WAKE_SOURCES[5] <= analog && p3_ff[3];
      WAKE_SOURCES[7:6] <= 2'h0;
    end
  end

  // reset pin drive length counter
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || BROWN_OUT_CONDITION) begin
      cnt_ff <= 32'h0000_0000;
    end else if (POR_EVENT || WDT_EVENT) begin
      cnt_ff <= POR_LEN;
    end else if (cnt_ff != 32'h0000_0000) begin
      cnt_ff <= cnt_ff - 32'h0000_0001;
    end
  end

  // reset pin drive flag for power-on and watchdog resets
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || BROWN_OUT_CONDITION) begin
      drv_ff <= 1'b0;
    end else if (POR_EVENT || WDT_EVENT) begin
      drv_ff <= 1'b1;
    end else if (cnt_ff <= 32'h0000_0001) begin
      drv_ff <= 1'b0;
    end
  end

  assign RESET_PIN_OUT_N = 1'b0;
  assign RESET_PIN_OE = drv_ff;
  assign RESET_PIN_PU_EN = !drv_ff;
  // external drivers are open-drain, so the sampled level is safe
  assign INT_RESET_N = p_rst_ff && !drv_ff;

  // wishbone read data and ack
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      dat_ff <= 32'h0000_0000;
      if (rd) begin
        unique case (WB_ADR)
          ADR_PORT0: dat_ff[7:0] <= p0_ff;
          ADR_PORT1: dat_ff[7:0] <= rd_p1;
          ADR_PORT2: dat_ff[7:0] <= p2_ff;
          ADR_PORT3: dat_ff[7:0] <= {lat3_ff, p3_ff};
          ADR_P0_MODE: dat_ff[1:0] <= p0_dir_ff;
          ADR_P2_MODE: dat_ff[7:0] <= p2_dir_ff;
          ADR_P3_MODE: dat_ff[7:0] <= p3m_ff;
          ADR_PCFG: dat_ff[7:0] <= pcfg_ff;
          ADR_IRQ_EDGE: dat_ff[7:0] <= irq_ff;
          ADR_TMR8: dat_ff[7:0] <= tmr8_ff;
          ADR_TMRC: dat_ff[7:0] <= tmrc_ff;
          ADR_TMR16: dat_ff[7:0] <= tmr16_ff;
          ADR_STATUS: dat_ff[7:0] <= WAKE_SOURCES;
          ADR_RST_CTRL: dat_ff[7:0] <= {6'h00, drv_ff, p_rst_ff};
          default: dat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign WB_ACK = ack_ff;
  assign WB_DAT_O = dat_ff;
endmodule

// ---- iop_ports_properties.sv ----
// concurrent checks on the i/o port block
`timescale 1ns/1ps
module iop_ports_properties #(
  parameter int unsigned POR_LEN = 8
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // bus
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_ACK,
  // pins
  input wire logic [7:0] P0_OE,
  input wire logic [7:0] P0_PU_EN,
  input wire logic [7:0] P2_OE,
  input wire logic [7:0] P2_PU_EN,
  // analog and power
  input wire logic CMP_PWR_EN,
  input wire logic STOP_MODE,
  input wire logic [2:0] PORT3_IRQ,
  input wire logic BROWN_OUT_CONDITION,
  // reset pin
  input wire logic RESET_PIN_OUT_N,
  input wire logic RESET_PIN_OE,
  input wire logic RESET_PIN_PU_EN
);
  localparam int HOLD_MIN = POR_LEN - 1;
  localparam int HOLD_MAX = POR_LEN + 2;
  logic [15:0] drv_ff;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // length of the current reset-pin drive
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || !RESET_PIN_OE) drv_ff <= 16'h0000;
    else drv_ff <= drv_ff + 16'h0001;
  end
  property p_pull_off;
    ((P0_OE & P0_PU_EN) | (P2_OE & P2_PU_EN)) == 8'h00;
  endproperty
  a_pull_off: assert property (p_pull_off)
    else $error("pull-up on output pin");
  property p_reset_in;
    $rose(RST_N) |-> P0_OE == 8'h00 && P2_OE == 8'h00;
  endproperty
  a_reset_in: assert property (p_reset_in)
    else $error("ports not input after reset");
  property p_rst_low;
    RESET_PIN_OE |-> !RESET_PIN_OUT_N && !RESET_PIN_PU_EN;
  endproperty
  a_rst_low: assert property (p_rst_low)
    else $error("reset pin drive not low or pull-up on");
  property p_rst_len;
    drv_ff <= HOLD_MAX && (!$fell(RESET_PIN_OE) || drv_ff >= HOLD_MIN);
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset pin drive length wrong");
  property p_brownout;
    BROWN_OUT_CONDITION && !RESET_PIN_OE |=> !RESET_PIN_OE;
  endproperty
  a_brownout: assert property (p_brownout)
    else $error("reset pin driven in brown-out");
  property p_stop_cmp;
    STOP_MODE |-> !CMP_PWR_EN;
  endproperty
  a_stop_cmp: assert property (p_stop_cmp)
    else $error("comparators powered in stop");
  property p_irq3;
    PORT3_IRQ[1] && !STOP_MODE |-> !CMP_PWR_EN;
  endproperty
  a_irq3: assert property (p_irq3)
    else $error("bit 3 interrupt in analog mode");
  property p_ack;
    WB_CYC && WB_STB && !WB_ACK |=> WB_ACK ##1 !WB_ACK;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer not one cycle");
endmodule
bind iop_ports iop_ports_properties #(.POR_LEN(POR_LEN)) iop_props_i (
  .SYS_CLK, .RST_N, .WB_CYC, .WB_STB, .WB_ACK, .P0_OE, .P0_PU_EN, .P2_OE,
  .P2_PU_EN, .CMP_PWR_EN, .STOP_MODE, .PORT3_IRQ, .BROWN_OUT_CONDITION,
  .RESET_PIN_OUT_N, .RESET_PIN_OE, .RESET_PIN_PU_EN);

// ---- iop_pins_model.sv ----
// pin-side model: external drivers, pull-ups, floating pins
`timescale 1ns/1ps
module iop_pins_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic [23:0] pad_out,
  input wire logic [23:0] pad_oe,
  input wire logic [23:0] pad_pu,
  input wire logic rst_out_n,
  input wire logic rst_oe,
  input wire logic rst_pu,
  // external circuits
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  input wire logic ext_rst_n,
  // sensed levels
  output logic [23:0] pad_in,
  output logic rst_line_n
);
  logic [23:0] drift_ff = 24'h5a5a5a;
  always_ff @(posedge clk) begin
    drift_ff <= ~drift_ff;
  end
  // undriven pins without pull-up show a changing pattern
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pu[i]) pad_in[i] = 1'b1;
      else pad_in[i] = drift_ff[i];
    end
  end
  // external reset driver only pulls low
  assign rst_line_n = rst_oe ? rst_out_n : !ext_rst_n ? 1'b0 :
                      rst_pu ? 1'b1 : drift_ff[0];
endmodule

// ---- testbench.sv ----
// self-checking bench for the four-port i/o block
`timescale 1ns/1ps
module testbench;
  import iop_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic WB_CYC = 1'b0, WB_STB = 1'b0, WB_WE = 1'b0, WB_ACK, got;
  logic [3:0] WB_SEL = 4'hf;
  logic [31:0] WB_ADR = 32'h0, WB_DAT_I = 32'h0, WB_DAT_O, q;
  logic [7:0] P0_IN, P0_OUT, P0_OE, P0_PU_EN, P1_IN, P1_OUT, P1_OE;
  logic [7:0] P1_PU_EN, P2_IN, P2_OUT, P2_OE, P2_PU_EN, WAKE_SOURCES;
  logic [3:0] P3_IN = 4'h8;
  logic [7:4] P3_OUT;
  logic CMP1_OUT = 1'b0, CMP2_OUT = 1'b0, T8_OUT = 1'b0, T16_OUT = 1'b0;
  logic ANDOR_OUT = 1'b0, STOP_MODE = 1'b0, STOP_RECOVERY = 1'b0;
  logic BROWN_OUT_CONDITION = 1'b0, POR_EVENT = 1'b0, WDT_EVENT = 1'b0;
  logic CMP_PWR_EN, EDGE_IN, RESET_PIN_IN_N, RESET_PIN_OUT_N, RESET_PIN_OE;
  logic RESET_PIN_PU_EN, INT_RESET_N, ext_rst_n = 1'b1;
  logic [2:0] PORT3_IRQ, seen;
  logic [23:0] ext_en = 24'h0, ext_val = 24'h0;
  int err_count = 0, n_compared = 0, cycles = 0;
  // rows: offset, data, {cmp2,cmp1,andor,t16,t8}, port 3 outputs
  logic [24:0] rows [8] = '{{8'h0c, 8'ha0, 5'h00, 4'ha},
    {8'h24, 8'h01, 5'h01, 4'h1}, {8'h2c, 8'h01, 5'h02, 4'h2},
    {8'h28, 8'h10, 5'h01, 4'h4}, {8'h28, 8'h20, 5'h02, 4'h4},
    {8'h28, 8'h30, 5'h04, 4'h4}, {8'h1c, 8'h01, 5'h08, 4'h1},
    {8'h1c, 8'h10, 5'h10, 4'h8}};
  // read-modify-write steps on port 0: op, operand, latch
  logic [17:0] rmw [3] = '{{OP_OR, 8'h03, 8'hcb}, {OP_XOR, 8'hff, 8'h34},
    {OP_AND, 8'hf0, 8'hc0}};
  iop_ports #(.POR_LEN(8)) iop_ports_i (
    .SYS_CLK, .RST_N, .WB_CYC, .WB_STB, .WB_WE, .WB_ADR, .WB_SEL,
    .WB_DAT_I, .WB_DAT_O, .WB_ACK, .P0_IN, .P0_OUT, .P0_OE, .P0_PU_EN,
    .P1_IN, .P1_OUT, .P1_OE, .P1_PU_EN, .P2_IN, .P2_OUT, .P2_OE,
    .P2_PU_EN, .P3_IN, .P3_OUT, .CMP1_OUT, .CMP2_OUT, .CMP_PWR_EN,
    .T8_OUT, .T16_OUT, .ANDOR_OUT, .EDGE_IN, .PORT3_IRQ, .STOP_MODE,
    .STOP_RECOVERY, .BROWN_OUT_CONDITION, .POR_EVENT, .WDT_EVENT,
    .WAKE_SOURCES, .RESET_PIN_IN_N, .RESET_PIN_OUT_N, .RESET_PIN_OE,
    .RESET_PIN_PU_EN, .INT_RESET_N);
  iop_pins_model iop_pins_model_i (
    .clk(SYS_CLK), .pad_out({P2_OUT, P1_OUT, P0_OUT}),
    .pad_oe({P2_OE, P1_OE, P0_OE}), .pad_pu({P2_PU_EN, P1_PU_EN, P0_PU_EN}),
    .rst_out_n(RESET_PIN_OUT_N), .rst_oe(RESET_PIN_OE),
    .rst_pu(RESET_PIN_PU_EN), .ext_en, .ext_val, .ext_rst_n,
    .pad_in({P2_IN, P1_IN, P0_IN}), .rst_line_n(RESET_PIN_IN_N));
  always #25 SYS_CLK = ~SYS_CLK;
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("FAIL %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic [31:0] a, d, input logic w);
    WB_ADR <= a;
    WB_DAT_I <= d;
    WB_WE <= w;
    WB_CYC <= 1'b1;
    WB_STB <= 1'b1;
    do @(posedge SYS_CLK); while (WB_ACK !== 1'b1);
    q = WB_DAT_O;
    WB_CYC <= 1'b0;
    WB_STB <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic wr(input logic [31:0] a, d);
    bus(a, d, 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, e);
    bus(a, 32'h0, 1'b0);
    chk(q, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  initial begin
    wt(20);
    RST_N <= 1'b1;
    wt(1);
    foreach (rows[i]) begin
      {CMP2_OUT, CMP1_OUT, ANDOR_OUT, T16_OUT, T8_OUT} <= rows[i][8:4];
      wr(rows[i][24:17], rows[i][16:9]);
      chk(P3_OUT, rows[i][3:0]);
      wr(rows[i][24:17], 32'h0);
    end
    $display("done: port 3 routing");
    ext_en <= 24'h7efff0;
    ext_val <= 24'h5a3cc0;
    wr(ADR_P0_MODE, 8'h01);
    wr(ADR_PORT0, 8'h5a);
    chk(P0_OE, 8'h0f);
    chk(P0_PU_EN, 8'hf0);
    wr(ADR_P2_MODE, 8'h81);
    wr(ADR_PORT2, 8'h01);
    chk(P2_OE, 8'h81);
    chk(P2_PU_EN, 8'h7e);
    chk(P2_OUT, 8'h01);
    rd(ADR_PORT0, 8'hca);
    rd(ADR_PORT2, 8'h5b);
    rd(ADR_PORT1, 8'h3c);
    wr(ADR_PCFG, 8'h0c);
    chk(P0_OE, 8'h05);
    chk(P2_OE, 8'h80);
    chk(P1_OE, 8'h00);
    chk(P1_PU_EN, 8'hff);
    wr(ADR_PCFG, 8'h00);
    foreach (rmw[i]) begin
      wt(4);
      wr(ADR_RMW, {rmw[i][17:16], 2'h0, rmw[i][15:8]});
      chk(P0_OUT, rmw[i][7:0]);
    end
    $display("done: ports");
    wr(ADR_P2_MODE, 8'h00);
    ext_en[23:16] <= 8'hff;
    ext_val[23:16] <= 8'h01;
    wr(ADR_P3_MODE, 8'h04);
    wt(5);
    chk(WAKE_SOURCES[1:0], 2'h1);
    chk(EDGE_IN, 1'b1);
    wr(ADR_P3_MODE, 8'h00);
    got = 1'b0;
    P3_IN <= 4'h0;
    repeat (8) begin
      @(posedge SYS_CLK);
      if (PORT3_IRQ[1] === 1'b1) got = 1'b1;
    end
    chk(got, 1'b1);
    chk(EDGE_IN, 1'b0);
    wr(ADR_IRQ_EDGE, 8'h40);
    seen = 3'h0;
    P3_IN <= 4'ha;
    repeat (8) begin
      @(posedge SYS_CLK);
      seen = seen | PORT3_IRQ;
    end
    chk(seen, 3'h4);
    chk(WAKE_SOURCES[4:2], 3'h5);
    wr(ADR_P3_MODE, 8'h02);
    chk(CMP_PWR_EN, 1'b1);
    chk(WAKE_SOURCES[5:2], 4'h8);
    STOP_MODE <= 1'b1;
    wr(ADR_P0_MODE, 8'h03);
    chk(CMP_PWR_EN, 1'b0);
    STOP_RECOVERY <= 1'b1;
    wt(1);
    STOP_RECOVERY <= 1'b0;
    STOP_MODE <= 1'b0;
    wt(2);
    chk(P0_OE, 8'h00);
    $display("done: wake and power");
    POR_EVENT <= 1'b1;
    wt(1);
    POR_EVENT <= 1'b0;
    wt(3);
    chk(RESET_PIN_IN_N, 1'b0);
    chk(INT_RESET_N, 1'b0);
    wt(12);
    chk(RESET_PIN_IN_N, 1'b1);
    chk(INT_RESET_N, 1'b1);
    BROWN_OUT_CONDITION <= 1'b1;
    WDT_EVENT <= 1'b1;
    wt(1);
    WDT_EVENT <= 1'b0;
    wt(3);
    chk(RESET_PIN_OE, 1'b0);
    BROWN_OUT_CONDITION <= 1'b0;
    ext_rst_n <= 1'b0;
    wt(4);
    chk(INT_RESET_N, 1'b0);
    ext_rst_n <= 1'b1;
    wt(4);
    rd(32'h40, 32'h0);
    WB_SEL <= 4'he;
    wr(ADR_PORT3, 8'hf0);
    chk(P3_OUT, 4'h0);
    WB_SEL <= 4'hf;
    wr(ADR_P2_MODE, 8'hff);
    RST_N <= 1'b0;
    wt(2);
    RST_N <= 1'b1;
    wt(1);
    chk(P2_OE, 8'h00);
    $display("done: reset and refusal");
    conclude();
  end
endmodule
